// ==== fcs_host_model.sv ====
// Purpose: spi host model issuing flash commands
// Assumes: mode 0; sclk stands low between frames
// Notes: so is sampled on rising sclk
`timescale 1ns/1ps
module fcs_host_model (
  output logic       sclk,
  output logic       cs_n,
  output logic       si,
  input  wire  logic so
);
  logic [7:0] rx;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  // top n bytes of w, msb first
  task automatic xfer(input logic [31:0] w, input int n);
    cs_n = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      si = w[31-i];
      #80 sclk = 1'b1;
      rx = {rx[6:0], so};
      #80 sclk = 1'b0;
    end
    // released line shows the inverse, not the last bit
    si = ~si;
    #80 cs_n = 1'b1;
    #400;
  endtask
endmodule // fcs_host_model

// ==== fcs_monitor.sv ====
// Purpose: port assertions for fcs_top
// Assumes: one clock, async active-low reset
// Notes: watches only the top-level ports
`timescale 1ns/1ps
module fcs_monitor #(
  parameter int NUM_BLOCKS = 8
) (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  spi_cs_n,
  input wire logic                  quad_io_enable,
  input wire logic                  spi_so_oe,
  input wire logic                  hold_function_on,
  input wire logic                  reset_function_on,
  input wire logic                  drive_full,
  input wire logic                  drive_two_thirds,
  input wire logic                  drive_one_third,
  input wire logic                  region_protect_on,
  input wire logic                  block_protect_on,
  input wire logic                  powerdown_active,
  input wire logic                  deepest_powerdown,
  input wire logic                  buffer_discard,
  input wire logic [NUM_BLOCKS-1:0] block_locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_role_one_hot: assert property (
    !(hold_function_on && reset_function_on)) else $error("two roles");
  a_quad_no_role: assert property (
    quad_io_enable [*3] |-> !hold_function_on && !reset_function_on)
    else $error("pin role with quad");
  a_drive_onehot: assert property (
    $onehot0({drive_full, drive_two_thirds, drive_one_third}))
    else $error("drive decode");
  a_scheme_pick: assert property (
    region_protect_on != block_protect_on) else $error("scheme");
  a_locks_reset: assert property (
    !$past(arst_n) |-> &block_locked) else $error("locks at reset");
  a_discard_deep: assert property (
    $rose(buffer_discard) |-> ##[0:4] deepest_powerdown) else $error("disc");
  a_deep_in_pd: assert property (
    deepest_powerdown |-> powerdown_active) else $error("deepest alone");
  a_cs_keeps_pd: assert property (
    powerdown_active && spi_cs_n && $past(spi_cs_n, 8) |=> powerdown_active)
    else $error("left power-down");
  a_so_idle: assert property (
    spi_cs_n [*4] |-> !spi_so_oe) else $error("so driven idle");
  cover property ($rose(deepest_powerdown));
  cover property (powerdown_active && !deepest_powerdown);
  cover property (block_protect_on && !(&block_locked));
endmodule // fcs_monitor
bind fcs_top fcs_monitor #(.NUM_BLOCKS(NUM_BLOCKS)) fcs_monitor_i (.*);

// ==== fcs_pkg.sv ====
// Purpose: constants shared by the flash configuration status block
// Assumes: one system clock; serial link pins are sampled by that clock
// Notes: opcodes for the status reads are fixed here as parameters of the map
//
// What this block does
// - top config bit picks hold or reset pin role
// - quad enable set disables hold and reset
// - drive field decodes full, two-thirds, one-third; resets 01
// - drive level applied while read data returns
// - scheme bit 0 selects region protection
// - scheme bit 1 selects per-block lock flags
// - all block locks set at any reset
// - lock 36h, unlock 39h update block flag
// - depth bit 0: B9h acts as 79h
// - depth bit 1: B9h keeps buffer contents
// - only ABh leaves either power-down state
// - chip select toggling alone keeps power-down
// - status writes need write enable and permission
package fcs_pkg;

  // -------------------------------------------------------------------------
  // command opcodes
  // -------------------------------------------------------------------------
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_WRDI      = 8'h04;
  localparam logic [7:0] OP_WRSR_A    = 8'h01;
  localparam logic [7:0] OP_WRSR_B    = 8'h31;
  localparam logic [7:0] OP_WRSR_CFG  = 8'h11;
  localparam logic [7:0] OP_WRSR_PWR  = 8'h71;
  localparam logic [7:0] OP_RDSR_CFG  = 8'h15;
  localparam logic [7:0] OP_RDSR_PWR  = 8'h35;
  localparam logic [7:0] OP_LOCK      = 8'h36;
  localparam logic [7:0] OP_UNLOCK    = 8'h39;
  localparam logic [7:0] OP_PD        = 8'hB9;
  localparam logic [7:0] OP_PD_DEEP   = 8'h79;
  localparam logic [7:0] OP_WAKE      = 8'hAB;

  // -------------------------------------------------------------------------
  // field layout of pin_drive_protect_config and power_mode_config
  // -------------------------------------------------------------------------
  localparam int         CFG_PIN_ROLE_BIT  = 7;
  localparam int         CFG_DRV_LSB       = 5;
  localparam int         CFG_SCHEME_BIT    = 2;
  localparam int         PWR_DEPTH_BIT     = 7;
  localparam logic [7:0] CFG_WRITE_MASK    = 8'hE4;
  localparam logic [7:0] PWR_WRITE_MASK    = 8'h80;
  localparam logic [7:0] CFG_RESET         = 8'h20;
  localparam logic [7:0] PWR_RESET         = 8'h00;

  localparam logic [1:0] DRV_RESERVED      = 2'h0;
  localparam logic [1:0] DRV_FULL          = 2'h1;
  localparam logic [1:0] DRV_TWO_THIRDS    = 2'h2;
  localparam logic [1:0] DRV_ONE_THIRD     = 2'h3;

  // -------------------------------------------------------------------------
  // transaction lengths in bytes, opcode included
  // -------------------------------------------------------------------------
  localparam logic [2:0] LEN_SIMPLE        = 3'h1;
  localparam logic [2:0] LEN_WRSR          = 3'h2;
  localparam logic [2:0] LEN_LOCK          = 3'h4;
  localparam logic [2:0] LEN_MAX           = 3'h7;

  typedef enum logic [1:0] {
    FCS_AWAKE,
    FCS_DEEP_PD,
    FCS_DEEPEST_PD
  } fcs_pwr_e;

endpackage

// ==== fcs_sync.sv ====
// Purpose: two-flop synchroniser for asynchronous inputs
// Assumes: inputs are levels, slow against clk
// Notes: stage one is read only by stage two
`timescale 1ns/1ps
module fcs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // fcs_sync

// ==== fcs_top.sv ====
// Purpose: config status registers, block locks and power-down control
// Assumes: spi mode 0; sclk, cs_n, si and the hold/reset pin are async
// Notes: sclk must stay at or below an eighth of clk; so needs 3 clk to move
`timescale 1ns/1ps
module fcs_top #(
  parameter int NUM_BLOCKS  = 8,
  parameter int BLOCK_SHIFT = 16
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_si,
  input  wire logic                  hold_reset_pin,
  input  wire logic                  quad_io_enable,
  input  wire logic                  sr_write_permit,
  output logic                       spi_so,
  output logic                       spi_so_oe,
  output logic                       hold_function_on,
  output logic                       reset_function_on,
  output logic                       device_reset,
  output logic                       drive_full,
  output logic                       drive_two_thirds,
  output logic                       drive_one_third,
  output logic                       region_protect_on,
  output logic                       block_protect_on,
  output logic [NUM_BLOCKS-1:0]      block_locked,
  output logic                       write_enable_latch,
  output logic                       powerdown_active,
  output logic                       deepest_powerdown,
  output logic                       buffer_discard
);

  localparam int IDX_W = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;

  // -------------------------------------------------------------------------
  // reset release and input synchronisers
  // -------------------------------------------------------------------------
  logic [1:0] rst_pipe_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  logic [3:0] pins_s;
  logic       sclk_s;
  logic       cs_act_s;
  logic       si_s;
  logic       hr_pin_s;

  // chip select is inverted before the synchroniser: its reset value of
  // zero then reads as deselected, so no false frame follows reset
  fcs_sync #(.WIDTH(4)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({spi_sclk, ~spi_cs_n, spi_si, hold_reset_pin}),
    .q     (pins_s)
  );
  assign sclk_s   = pins_s[3];
  assign cs_act_s = pins_s[2];
  assign si_s     = pins_s[1];
  assign hr_pin_s = pins_s[0];

  // -------------------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------------------
  function automatic logic fcs_is_sr_write(input logic [7:0] op);
    return (op == fcs_pkg::OP_WRSR_A) || (op == fcs_pkg::OP_WRSR_B) ||
           (op == fcs_pkg::OP_WRSR_CFG) || (op == fcs_pkg::OP_WRSR_PWR);
  endfunction

  // -------------------------------------------------------------------------
  // link edges and frame capture
  // -------------------------------------------------------------------------
  logic        sclk_d_q;
  logic        cs_d_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        frame_end;
  logic [5:0]  bit_cnt_q;
  logic [23:0] sh_q;
  logic [7:0]  cmd_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_q <= 1'b0;
      cs_d_q   <= 1'b0;
    end else begin
      sclk_d_q <= sclk_s;
      cs_d_q   <= cs_act_s;
    end
  end
  assign sclk_rise = cs_act_s & sclk_s & ~sclk_d_q;
  assign sclk_fall = cs_act_s & ~sclk_s & sclk_d_q;
  // bit_cnt_q still holds the frame length in the cycle frame_end is high
  assign frame_end = cs_d_q & ~cs_act_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 6'h00;
      sh_q      <= 24'h000000;
      cmd_q     <= 8'h00;
    end else if (!cs_act_s) begin
      bit_cnt_q <= 6'h00;
    end else if (sclk_rise) begin
      sh_q <= {sh_q[22:0], si_s};
      if (bit_cnt_q == 6'h07) begin
        cmd_q <= {sh_q[6:0], si_s};
      end
      // saturate so an overlong frame matches no command length
      if (bit_cnt_q != 6'h3F) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  logic [7:0] data_byte;
  logic       end_simple;
  logic       end_wrsr;
  logic       end_addr;

  assign data_byte  = sh_q[7:0];
  assign end_simple = frame_end &&
                      (bit_cnt_q == {fcs_pkg::LEN_SIMPLE, 3'h0});
  assign end_wrsr   = frame_end && (bit_cnt_q == {fcs_pkg::LEN_WRSR, 3'h0});
  assign end_addr   = frame_end && (bit_cnt_q == {fcs_pkg::LEN_LOCK, 3'h0});

  // -------------------------------------------------------------------------
  // configuration state
  // -------------------------------------------------------------------------
  logic [7:0]            cfg_q;
  logic [7:0]            pwr_q;
  logic [NUM_BLOCKS-1:0] lock_q;
  logic                  we_latch_q;
  logic                  awake;
  logic                  wr_ok;
  fcs_pkg::fcs_pwr_e     pwr_state_q;

  assign awake = (pwr_state_q == fcs_pkg::FCS_AWAKE);
  assign wr_ok = end_wrsr && awake && we_latch_q && sr_write_permit &&
                 fcs_is_sr_write(cmd_q);

  // only the writable bits are stored, so reserved bits always read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= fcs_pkg::CFG_RESET;
    end else if (wr_ok && (cmd_q == fcs_pkg::OP_WRSR_CFG)) begin
      cfg_q <= data_byte & fcs_pkg::CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= fcs_pkg::PWR_RESET;
    end else if (wr_ok && (cmd_q == fcs_pkg::OP_WRSR_PWR)) begin
      pwr_q <= data_byte & fcs_pkg::PWR_WRITE_MASK;
    end
  end

  logic dev_rst_q;

  // any two-byte status write frame while awake spends the latch, refused or not, so a later
  // write cannot ride on an enable meant for an earlier one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_latch_q <= 1'b0;
    end else if (dev_rst_q) begin
      we_latch_q <= 1'b0;
    end else if (awake && end_simple && (cmd_q == fcs_pkg::OP_WREN)) begin
      we_latch_q <= 1'b1;
    end else if (awake && end_simple && (cmd_q == fcs_pkg::OP_WRDI)) begin
      we_latch_q <= 1'b0;
    end else if (awake && end_wrsr && fcs_is_sr_write(cmd_q)) begin
      we_latch_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // block locks
  // -------------------------------------------------------------------------
  logic [IDX_W-1:0] blk_idx;
  logic             lock_cmd;
  logic             unlock_cmd;

  assign blk_idx    = sh_q[BLOCK_SHIFT +: IDX_W];
  assign lock_cmd   = end_addr && awake && cfg_q[fcs_pkg::CFG_SCHEME_BIT] &&
                      (cmd_q == fcs_pkg::OP_LOCK);
  assign unlock_cmd = end_addr && awake && cfg_q[fcs_pkg::CFG_SCHEME_BIT] &&
                      (cmd_q == fcs_pkg::OP_UNLOCK);

  for (genvar gi = 0; gi < NUM_BLOCKS; gi++) begin : g_lock
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        lock_q[gi] <= 1'b1;
      end else if (dev_rst_q) begin
        lock_q[gi] <= 1'b1;
      end else if (lock_cmd && (blk_idx == IDX_W'(gi))) begin
        lock_q[gi] <= 1'b1;
      end else if (unlock_cmd && (blk_idx == IDX_W'(gi))) begin
        lock_q[gi] <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // power-down control
  // -------------------------------------------------------------------------
  logic pd_q;
  logic deepest_q;
  logic discard_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state_q <= fcs_pkg::FCS_AWAKE;
      pd_q        <= 1'b0;
      deepest_q   <= 1'b0;
      discard_q   <= 1'b0;
    end else begin
      discard_q <= 1'b0;
      case (pwr_state_q)
        fcs_pkg::FCS_AWAKE: begin
          if (end_simple && ((cmd_q == fcs_pkg::OP_PD_DEEP) ||
              ((cmd_q == fcs_pkg::OP_PD) &&
               !pwr_q[fcs_pkg::PWR_DEPTH_BIT]))) begin
            pwr_state_q <= fcs_pkg::FCS_DEEPEST_PD;
            pd_q        <= 1'b1;
            deepest_q   <= 1'b1;
            discard_q   <= 1'b1;
          end else if (end_simple && (cmd_q == fcs_pkg::OP_PD)) begin
            pwr_state_q <= fcs_pkg::FCS_DEEP_PD;
            pd_q        <= 1'b1;
            deepest_q   <= 1'b0;
          end
        end
        fcs_pkg::FCS_DEEP_PD, fcs_pkg::FCS_DEEPEST_PD: begin
          // a bare select pulse ends no frame with the wake code: stay put
          if (end_simple && (cmd_q == fcs_pkg::OP_WAKE)) begin
            pwr_state_q <= fcs_pkg::FCS_AWAKE;
            pd_q        <= 1'b0;
            deepest_q   <= 1'b0;
          end
        end
        default: begin
          pwr_state_q <= fcs_pkg::FCS_AWAKE;
          pd_q        <= 1'b0;
          deepest_q   <= 1'b0;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // pin role, drive level and protection scheme outputs
  // -------------------------------------------------------------------------
  logic       hold_q;
  logic       reset_role_q;
  logic [2:0] drv_q;
  logic       region_q;
  logic       block_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q       <= 1'b1;
      reset_role_q <= 1'b0;
      dev_rst_q    <= 1'b0;
      region_q     <= 1'b1;
      block_q      <= 1'b0;
    end else begin
      hold_q       <= !quad_io_enable &&
                      !cfg_q[fcs_pkg::CFG_PIN_ROLE_BIT];
      reset_role_q <= !quad_io_enable &&
                      cfg_q[fcs_pkg::CFG_PIN_ROLE_BIT];
      dev_rst_q    <= !quad_io_enable &&
                      cfg_q[fcs_pkg::CFG_PIN_ROLE_BIT] && !hr_pin_s;
      region_q     <= !cfg_q[fcs_pkg::CFG_SCHEME_BIT];
      block_q      <= cfg_q[fcs_pkg::CFG_SCHEME_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_q <= 3'h4;
    end else begin
      case (cfg_q[fcs_pkg::CFG_DRV_LSB +: 2])
        fcs_pkg::DRV_FULL:       drv_q <= 3'h4;
        fcs_pkg::DRV_TWO_THIRDS: drv_q <= 3'h2;
        fcs_pkg::DRV_ONE_THIRD:  drv_q <= 3'h1;
        default:                 drv_q <= 3'h0;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // read data return
  // -------------------------------------------------------------------------
  logic       rd_cmd;
  logic [7:0] rd_val;
  logic [7:0] tx_q;
  logic       so_q;
  logic       so_oe_q;

  assign rd_cmd = awake && ((cmd_q == fcs_pkg::OP_RDSR_CFG) ||
                            (cmd_q == fcs_pkg::OP_RDSR_PWR));
  assign rd_val = (cmd_q == fcs_pkg::OP_RDSR_PWR) ? pwr_q : cfg_q;

  // mode 0: the next bit is set up on the falling edge, reloaded per byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q    <= 8'h00;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (!cs_act_s) begin
      so_oe_q <= 1'b0;
    end else if (sclk_fall && rd_cmd && (bit_cnt_q >= 6'h08)) begin
      so_oe_q <= 1'b1;
      if (bit_cnt_q[2:0] == 3'h0) begin
        so_q <= rd_val[7];
        tx_q <= {rd_val[6:0], 1'b0};
      end else begin
        so_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign spi_so             = so_q;
  assign spi_so_oe          = so_oe_q;
  assign hold_function_on   = hold_q;
  assign reset_function_on  = reset_role_q;
  assign device_reset       = dev_rst_q;
  assign drive_full         = drv_q[2];
  assign drive_two_thirds   = drv_q[1];
  assign drive_one_third    = drv_q[0];
  assign region_protect_on  = region_q;
  assign block_protect_on   = block_q;
  assign block_locked       = lock_q;
  assign write_enable_latch = we_latch_q;
  assign powerdown_active   = pd_q;
  assign deepest_powerdown  = deepest_q;
  assign buffer_discard     = discard_q;

endmodule // fcs_top

// ==== testbench.sv ====
// Purpose: self-checking bench for fcs_top
// Assumes: host model drives the link
// Notes: expectations from a small integer model
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, arst_n = 1'b0, quad_io_enable = 1'b0;
  logic sr_write_permit = 1'b1, hold_reset_pin = 1'b1, spi_so, spi_so_oe;
  logic spi_sclk, spi_cs_n, spi_si, hold_function_on, reset_function_on;
  logic device_reset, drive_full, drive_two_thirds, drive_one_third;
  logic region_protect_on, block_protect_on, write_enable_latch;
  logic powerdown_active, deepest_powerdown, buffer_discard;
  logic [7:0] block_locked, v, g;
  int fail_count = 0, checks = 0, b;
  fcs_top fcs_top_i (.*);
  fcs_host_model fcs_host_model_i (.sclk(spi_sclk), .cs_n(spi_cs_n),
    .si(spi_si), .so(spi_so));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [31:0] w, input int n);
    fcs_host_model_i.xfer(w, n);
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    op(32'h06000000, 1);
    chk(write_enable_latch, 8'h01);
    op({o, d, 16'h0000}, 2);
  endtask
  task automatic rdchk(input logic [7:0] o, input logic [7:0] exp);
    op({o, 24'h000000}, 2);
    chk(fcs_host_model_i.rx, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1000000 fail_count++;
    end_sim;
  end
  initial begin
    void'($urandom(32'hBBAF));
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    rdchk(8'h15, 8'h20);
    rdchk(8'h35, 8'h00);
    chk(block_locked, 8'hFF);
    for (int d = 1; d < 4; d++) begin
      v = (8'($urandom) & 8'h9F) | 8'(d << 5);
      wr(8'h11, v);
      rdchk(8'h15, v & 8'hE4);
      g = {5'h00, drive_full, drive_two_thirds, drive_one_third};
      chk(g, 8'(4 >> (d - 1)));
      g = {4'h0, hold_function_on, reset_function_on, block_protect_on,
        region_protect_on};
      chk(g, {4'h0, ~v[7], v[7], v[2], ~v[2]});
    end
    @(posedge clk);
    #1 quad_io_enable = 1'b1;
    sr_write_permit = 1'b0;
    wr(8'h11, 8'h24);
    rdchk(8'h15, v & 8'hE4);
    chk({hold_function_on, reset_function_on}, 8'h00);
    sr_write_permit = 1'b1;
    op(32'h11240000, 2);
    rdchk(8'h15, v & 8'hE4);
    wr(8'h11, 8'h24);
    b = $urandom % 8;
    op({8'h39, 8'(b), 16'h0000}, 4);
    chk(block_locked, ~(8'h01 << b));
    op({8'h36, 8'(b), 16'h0000}, 4);
    chk(block_locked, 8'hFF);
    $display("config and locks done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h71, i == 1 ? 8'h80 : 8'h00);
      op(i == 2 ? 32'h79000000 : 32'hB9000000, 1);
      op(32'h06000000, 1);
      chk({powerdown_active, deepest_powerdown}, i == 1 ? 8'h02 : 8'h03);
      op(32'hAB000000, 1);
      chk(powerdown_active, 8'h00);
    end
    $display("power-down done");
    end_sim;
  end
endmodule // testbench
